// file: verilog/crypto_cfg_pkg.sv
// package for the crypto engine reset, enable and start-up configuration loader
// assumes one system clock; the register bus is AXI4-Lite with 32-bit data
package crypto_cfg_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned AXI_AW        = 8;
    localparam logic [7:0]  OFF_CTRL_LOW  = 8'h00;
    localparam logic [7:0]  OFF_CTRL_HIGH = 8'h04;
    localparam logic [7:0]  OFF_STATUS    = 8'h08;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h0C;
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h10;
    localparam logic [7:0]  OFF_PWR       = 8'h14;
    localparam logic [7:0]  ADDR_WORD     = 8'hFC;

    // ------------------------------------------------------------
    // control low fields
    // ------------------------------------------------------------
    localparam int unsigned CL_ENGINE_ON  = 15;
    localparam int unsigned CL_IDLE_HALT  = 13;
    localparam int unsigned CL_ROLL_IE    = 12;
    localparam int unsigned CL_FINISH_IE  = 11;
    localparam int unsigned CL_FREE_IE    = 10;
    localparam int unsigned CL_GO         = 0;
    localparam logic [15:0] CTRL_LOW_RST  = 16'h0000;
    localparam logic [15:0] CTRL_LOW_WMSK = 16'hBC01;
    localparam logic [15:0] CTRL_LOW_OFF  = 16'h0001;

    // ------------------------------------------------------------
    // control high fields
    // ------------------------------------------------------------
    localparam int unsigned CH_CTR_LSB    = 8;
    localparam int unsigned CH_SKEY_SEL   = 7;
    localparam int unsigned CH_KLEN_LSB   = 5;
    localparam int unsigned CH_KEY_ERASE  = 4;
    localparam int unsigned CH_KSRC_LSB   = 0;
    localparam logic [15:0] CTRL_HIGH_RST = 16'h0000;
    localparam logic [15:0] CTRL_HIGH_WMSK = 16'h7FFF;
    localparam logic [15:0] CTRL_HIGH_OFF = 16'h0010;
    localparam logic [15:0] CTRL_HIGH_KEEP = 16'h000F;

    // ------------------------------------------------------------
    // status, interrupt and power fields
    // ------------------------------------------------------------
    localparam int unsigned ST_BUSY       = 7;
    localparam int unsigned ST_READ       = 6;
    localparam int unsigned ST_OP         = 3;
    localparam int unsigned ST_PGM_FAIL   = 2;
    localparam int unsigned ST_KEY_FAIL   = 1;
    localparam int unsigned ST_TST_PGM    = 0;
    localparam int unsigned IRQ_W         = 3;
    localparam int unsigned IRQ_LOAD      = 0;
    localparam int unsigned IRQ_DONE      = 1;
    localparam int unsigned IRQ_REFUSE    = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST  = 3'h0;
    localparam int unsigned PWR_GATE      = 0;

    // ------------------------------------------------------------
    // configuration page layout and timing
    // ------------------------------------------------------------
    localparam int unsigned CFG_PAGE_W    = 2;
    localparam logic [CFG_PAGE_W-1:0] CFG_PAGE_BOOT = 2'h0;
    localparam int unsigned CFG_TEST_BIT  = 0;
    localparam int unsigned CFG_LOCK_BIT  = 1;
    localparam int unsigned CFG_KLIM_LSB  = 4;
    localparam logic [31:0] CFG_RST       = 32'h00000000;
    localparam logic [15:0] OP_CYCLES_DEF = 16'd219;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

    typedef enum logic [2:0] {
        LD_FETCH = 3'b001,
        LD_READY = 3'b010,
        LD_HALT  = 3'b100
    } ld_state_t;

endpackage : crypto_cfg_pkg

// file: verilog/crypto_cfg_loader.sv
// crypto engine control registers, gating, reset and start-up configuration load
// assumes the configuration array answers on SYS_CLK; sleep and idle pins are asynchronous
//
// Overview of operation
// - disable bit gates all engine clocks
// - gated: control writes ignored, reads invalid
// - engine runs only with disable bit cleared
// - device reset restores every control default
// - disable bit resets most control bits
// - engine off resets a further subset
// - any deactivation ends running operation
// - after reset, load configuration page zero
// - read flag set and cleared by hardware
// - operations refused until load completes
// - wake from sleep repeats the load
// - read and busy flags high while loading
// - failure flags zero while loading, derived after
// - test status zero while loading, copies after
// - sleep halts operations and resets state
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
module crypto_cfg_loader
    import crypto_cfg_pkg::*;
#(
    parameter logic [15:0] OP_CYCLES = OP_CYCLES_DEF
)(
    input  wire logic              SYS_CLK,
    input  wire logic              RST_N,
    input  wire axil_req_t         S_AXI_REQ,
    output axil_rsp_t              S_AXI_RSP,
    input  wire logic              SLEEP_REQ,
    input  wire logic              IDLE_REQ,
    output logic                   CFG_RD_REQ,
    output logic [CFG_PAGE_W-1:0]  CFG_RD_PAGE,
    input  wire logic              CFG_RD_ACK,
    input  wire logic [31:0]       CFG_RD_DATA,
    output logic                   ENGINE_CLK_EN,
    output logic                   ENGINE_READY,
    output logic                   OP_BUSY,
    output logic                   IRQ
);

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_q;
    logic [1:0] rst_d;
    logic       rst_n;
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] pin_s1_d;
    logic [1:0] pin_s2_d;
    always_comb begin
        rst_d    = {rst_q[0], 1'b1};
        pin_s1_d = {IDLE_REQ, SLEEP_REQ};
        pin_s2_d = pin_s1_q;
    end
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= rst_d;
        end
    end
    assign rst_n = rst_q[1];

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
        end
    end

    // ------------------------------------------------------------
    // state shared between the groups
    // ------------------------------------------------------------
    ld_state_t   ld_q;
    ld_state_t   ld_d;
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic        req_q;
    logic        req_d;
    logic        ld_evt;
    logic        halt;
    logic        gate_q;
    logic        gate_d;
    logic [15:0] ctrl_low_q;
    logic [15:0] ctrl_low_d;
    logic [15:0] ctrl_high_q;
    logic [15:0] ctrl_high_d;
    // idle counts as sleep only when the halt-in-idle bit is set
    assign halt = pin_s2_q[0] | (pin_s2_q[1] & ctrl_low_q[CL_IDLE_HALT]);

    // ------------------------------------------------------------
    // configuration load sequencer
    // ------------------------------------------------------------
    always_comb begin
        ld_d   = ld_q;
        cfg_d  = cfg_q;
        ld_evt = 1'b0;
        unique case (ld_q)
            LD_FETCH: begin
                if (halt) begin
                    ld_d = LD_HALT;
                end else if (req_q && CFG_RD_ACK) begin
                    cfg_d  = CFG_RD_DATA;
                    ld_d   = LD_READY;
                    ld_evt = 1'b1;
                end
            end
            LD_READY: begin
                if (halt) begin
                    ld_d = LD_HALT;
                end
            end
            LD_HALT: begin
                if (!halt) begin
                    ld_d = LD_FETCH;
                end
            end
            default: begin
                ld_d = LD_FETCH;
            end
        endcase
        // a stopped clock cannot fetch, so the request waits while gated
        req_d = (ld_d == LD_FETCH) && !gate_d;
    end
    // only the boot page is ever fetched by this sequencer
    logic [CFG_PAGE_W-1:0] page_q;
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ld_q   <= LD_FETCH;
            cfg_q  <= CFG_RST;
            req_q  <= 1'b0;
            page_q <= CFG_PAGE_BOOT;
        end else begin
            ld_q   <= ld_d;
            cfg_q  <= cfg_d;
            req_q  <= req_d;
            page_q <= CFG_PAGE_BOOT;
        end
    end

    // ------------------------------------------------------------
    // status derived from the load
    // ------------------------------------------------------------
    logic        loaded;
    logic        key_fail;
    logic        pgm_fail;
    logic [15:0] status;
    assign loaded   = (ld_q == LD_READY);
    assign key_fail = loaded && (ctrl_high_q[CH_KSRC_LSB +: 4]
                      > cfg_q[CFG_KLIM_LSB +: 4]);
    assign pgm_fail = loaded && cfg_q[CFG_LOCK_BIT]
                      && !cfg_q[CFG_TEST_BIT];
    always_comb begin
        status              = 16'h0000;
        status[ST_BUSY]     = (ld_q == LD_FETCH);
        status[ST_READ]     = (ld_q == LD_FETCH);
        status[ST_OP]       = ctrl_low_q[CL_GO];
        status[ST_PGM_FAIL] = pgm_fail;
        status[ST_KEY_FAIL] = key_fail;
        status[ST_TST_PGM]  = loaded && cfg_q[CFG_TEST_BIT];
    end

    // ------------------------------------------------------------
    // bus slave, registers and operation timer
    // ------------------------------------------------------------
    logic              aw_q;
    logic              aw_d;
    logic [AXI_AW-1:0] awaddr_q;
    logic [AXI_AW-1:0] awaddr_d;
    logic              w_q;
    logic              w_d;
    logic [31:0]       wdata_q;
    logic [31:0]       wdata_d;
    logic [3:0]        wstrb_q;
    logic [3:0]        wstrb_d;
    axil_rsp_t         rsp_q;
    axil_rsp_t         rsp_d;
    logic [15:0]       cnt_q;
    logic [15:0]       cnt_d;
    logic [IRQ_W-1:0]  irq_st_q;
    logic [IRQ_W-1:0]  irq_st_d;
    logic [IRQ_W-1:0]  irq_msk_q;
    logic [IRQ_W-1:0]  irq_msk_d;
    logic              irq_q;
    logic              irq_d;
    logic              clk_en_q;
    logic              ready_q;
    logic              ready_d;
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb,
        input logic [15:0] wmsk
    );
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmsk;
        return (old & ~lanes) | (data[15:0] & lanes);
    endfunction : merge16
    always_comb begin
        logic [7:0]       wa;
        logic [7:0]       ra;
        logic             wr_go;
        logic             hit;
        logic [15:0]      nl;
        logic [IRQ_W-1:0] evt;
        logic [IRQ_W-1:0] w1c;
        wa          = awaddr_q & ADDR_WORD;
        ra          = S_AXI_REQ.araddr & ADDR_WORD;
        wr_go       = aw_q && w_q && !rsp_q.bvalid;
        hit         = 1'b0;
        nl          = ctrl_low_q;
        evt         = '0;
        w1c         = '0;
        aw_d        = aw_q;
        awaddr_d    = awaddr_q;
        w_d         = w_q;
        wdata_d     = wdata_q;
        wstrb_d     = wstrb_q;
        rsp_d       = rsp_q;
        cnt_d       = cnt_q;
        gate_d      = gate_q;
        ctrl_low_d  = ctrl_low_q;
        ctrl_high_d = ctrl_high_q;
        irq_msk_d   = irq_msk_q;
        evt[IRQ_LOAD] = ld_evt;
        // operation timer: completion clears go by hardware
        if (ctrl_low_q[CL_GO]) begin
            if (cnt_q <= 16'h0001) begin
                ctrl_low_d[CL_GO] = 1'b0;
                evt[IRQ_DONE]     = 1'b1;
            end else begin
                cnt_d = cnt_q - 16'h0001;
            end
        end
        // write channels are taken independently, in either order
        if (S_AXI_REQ.awvalid && rsp_q.awready) begin
            aw_d     = 1'b1;
            awaddr_d = S_AXI_REQ.awaddr;
        end
        if (S_AXI_REQ.wvalid && rsp_q.wready) begin
            w_d     = 1'b1;
            wdata_d = S_AXI_REQ.wdata;
            wstrb_d = S_AXI_REQ.wstrb;
        end
        if (rsp_q.bvalid && S_AXI_REQ.bready) begin
            rsp_d.bvalid = 1'b0;
        end
        if (wr_go) begin
            aw_d         = 1'b0;
            w_d          = 1'b0;
            rsp_d.bvalid = 1'b1;
            if (wa == OFF_PWR) begin
                hit = 1'b1;
                if (wstrb_q[0]) begin
                    gate_d = wdata_q[PWR_GATE];
                end
            end else if (gate_q) begin
                // gated block: a register write is swallowed with an okay answer; an unmapped address gets an error
                hit = (wa == OFF_CTRL_LOW) || (wa == OFF_CTRL_HIGH)
                      || (wa == OFF_STATUS) || (wa == OFF_IRQ_STAT)
                      || (wa == OFF_IRQ_MASK);
            end else if (wa == OFF_CTRL_LOW) begin
                hit = 1'b1;
                nl  = merge16(ctrl_low_q, wdata_q, wstrb_q, CTRL_LOW_WMSK);
                if (nl[CL_GO] && !ctrl_low_q[CL_GO]) begin
                    if (loaded && nl[CL_ENGINE_ON]) begin
                        cnt_d = OP_CYCLES;
                    end else begin
                        nl[CL_GO]       = 1'b0;
                        evt[IRQ_REFUSE] = 1'b1;
                    end
                end
                ctrl_low_d = nl;
            end else if (wa == OFF_CTRL_HIGH) begin
                hit         = 1'b1;
                ctrl_high_d = merge16(ctrl_high_q, wdata_q, wstrb_q,
                                      CTRL_HIGH_WMSK);
            end else if (wa == OFF_STATUS) begin
                hit = 1'b1;
            end else if (wa == OFF_IRQ_STAT) begin
                hit = 1'b1;
                w1c = wstrb_q[0] ? wdata_q[IRQ_W-1:0] : '0;
            end else if (wa == OFF_IRQ_MASK) begin
                hit = 1'b1;
                if (wstrb_q[0]) begin
                    irq_msk_d = wdata_q[IRQ_W-1:0];
                end
            end
            rsp_d.bresp = hit ? RESP_OKAY : RESP_SLVERR;
        end
        // read channel: answer in the cycle after the address is taken
        if (rsp_q.rvalid && S_AXI_REQ.rready) begin
            rsp_d.rvalid = 1'b0;
        end
        if (S_AXI_REQ.arvalid && rsp_q.arready) begin
            rsp_d.rvalid = 1'b1;
            rsp_d.rresp  = RESP_OKAY;
            rsp_d.rdata  = 32'h00000000;
            if (ra == OFF_PWR) begin
                rsp_d.rdata[PWR_GATE] = gate_q;
            end else if (gate_q) begin
                rsp_d.rdata = 32'h00000000;
            end else if (ra == OFF_CTRL_LOW) begin
                rsp_d.rdata[15:0] = ctrl_low_q;
            end else if (ra == OFF_CTRL_HIGH) begin
                rsp_d.rdata[15:0] = ctrl_high_q;
            end else if (ra == OFF_STATUS) begin
                rsp_d.rdata[15:0] = status;
            end else if (ra == OFF_IRQ_STAT) begin
                rsp_d.rdata[IRQ_W-1:0] = irq_st_q;
            end else if (ra == OFF_IRQ_MASK) begin
                rsp_d.rdata[IRQ_W-1:0] = irq_msk_q;
            end else begin
                rsp_d.rresp = RESP_SLVERR;
            end
        end
        // deactivation paths, strongest last
        if (!ctrl_low_d[CL_ENGINE_ON]) begin
            ctrl_low_d  = ctrl_low_d & ~CTRL_LOW_OFF;
            ctrl_high_d = ctrl_high_d & ~CTRL_HIGH_OFF;
        end
        if (halt) begin
            ctrl_low_d[CL_GO] = 1'b0;
        end
        if (gate_d) begin
            // key source survives so its validity can still be checked
            ctrl_low_d  = CTRL_LOW_RST;
            ctrl_high_d = (ctrl_high_d & CTRL_HIGH_KEEP)
                          | (CTRL_HIGH_RST & ~CTRL_HIGH_KEEP);
        end
        if (!ctrl_low_d[CL_GO]) begin
            cnt_d = 16'h0000;
        end
        rsp_d.awready = !aw_d && !rsp_d.bvalid;
        rsp_d.wready  = !w_d && !rsp_d.bvalid;
        rsp_d.arready = !rsp_d.rvalid;
        // a new event wins over a clear in the same cycle
        irq_st_d = gate_q ? irq_st_q : ((irq_st_q & ~w1c) | evt);
        irq_d    = |(irq_st_d & irq_msk_d);
        ready_d  = (ld_d == LD_READY) && !gate_d
                   && ctrl_low_d[CL_ENGINE_ON];
    end
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_q        <= 1'b0;
            awaddr_q    <= '0;
            w_q         <= 1'b0;
            wdata_q     <= 32'h00000000;
            wstrb_q     <= 4'h0;
            rsp_q       <= '0;
            cnt_q       <= 16'h0000;
            gate_q      <= 1'b0;
            ctrl_low_q  <= CTRL_LOW_RST;
            ctrl_high_q <= CTRL_HIGH_RST;
            irq_st_q    <= IRQ_RST;
            irq_msk_q   <= IRQ_RST;
            irq_q       <= 1'b0;
            clk_en_q    <= 1'b0;
            ready_q     <= 1'b0;
        end else begin
            aw_q        <= aw_d;
            awaddr_q    <= awaddr_d;
            w_q         <= w_d;
            wdata_q     <= wdata_d;
            wstrb_q     <= wstrb_d;
            rsp_q       <= rsp_d;
            cnt_q       <= cnt_d;
            gate_q      <= gate_d;
            ctrl_low_q  <= ctrl_low_d;
            ctrl_high_q <= ctrl_high_d;
            irq_st_q    <= irq_st_d;
            irq_msk_q   <= irq_msk_d;
            irq_q       <= irq_d;
            clk_en_q    <= !gate_d;
            ready_q     <= ready_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign S_AXI_RSP     = rsp_q;
    assign CFG_RD_REQ    = req_q;
    assign ENGINE_CLK_EN = clk_en_q;
    assign ENGINE_READY  = ready_q;
    assign OP_BUSY       = ctrl_low_q[CL_GO];
    assign IRQ           = irq_q;
    assign CFG_RD_PAGE   = page_q;

endmodule : crypto_cfg_loader

// file: verification/cfg_array_model.sv
// model of the one-time-programmable configuration array behind the loader
// assumes fetch requests are levels on the same clock; answers dly+1 cycles after the request
module cfg_array_model (
    input  wire logic        clk,
    input  wire logic        req,
    input  wire logic [31:0] word,
    input  wire logic [3:0]  dly,
    output logic             ack,
    output logic [31:0]      data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    initial ack = 1'b0;
    initial data = 32'h0;
    // data toggles outside the answer so a stale word is never mistaken for fresh
    always @(posedge clk) begin
        ack  <= 1'b0;
        data <= ~data;
        cnt  <= req ? cnt + 4'h1 : 4'h0;
        if (req && !ack && cnt == dly) begin
            ack  <= 1'b1;
            data <= word;
        end
    end
endmodule : cfg_array_model

// file: verification/crypto_cfg_loader_asserts.sv
// concurrent checks on the loader ports
// assumes RST_N is the raw pin; outputs are still held while it resyncs
module crypto_cfg_loader_asserts
    import crypto_cfg_pkg::*;
#(
    parameter logic [15:0] OP_CYCLES = OP_CYCLES_DEF
)(
    input wire logic                  SYS_CLK,
    input wire logic                  RST_N,
    input wire axil_req_t             S_AXI_REQ,
    input wire axil_rsp_t             S_AXI_RSP,
    input wire logic                  SLEEP_REQ,
    input wire logic                  IDLE_REQ,
    input wire logic                  CFG_RD_REQ,
    input wire logic [CFG_PAGE_W-1:0] CFG_RD_PAGE,
    input wire logic                  CFG_RD_ACK,
    input wire logic [31:0]           CFG_RD_DATA,
    input wire logic                  ENGINE_CLK_EN,
    input wire logic                  ENGINE_READY,
    input wire logic                  OP_BUSY,
    input wire logic                  IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    logic [15:0] busy_cnt_q;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) busy_cnt_q <= 16'h0;
        else busy_cnt_q <= OP_BUSY ? busy_cnt_q + 16'h1 : 16'h0;
    end
    ready_needs_clk_a: assert property (ENGINE_READY |-> ENGINE_CLK_EN)
        else $error("engine ready while clock gated");
    ready_after_load_a: assert property (CFG_RD_REQ |-> !ENGINE_READY)
        else $error("engine ready during configuration fetch");
    fetch_ends_a: assert property (CFG_RD_REQ && CFG_RD_ACK |=> !CFG_RD_REQ)
        else $error("fetch request held after answer");
    boot_page_a: assert property (CFG_RD_REQ |-> CFG_RD_PAGE == CFG_PAGE_BOOT)
        else $error("fetch of wrong page");
    go_refused_a: assert property ($rose(OP_BUSY) |-> ENGINE_CLK_EN && !CFG_RD_REQ)
        else $error("operation started while unavailable");
    op_length_a: assert property (OP_BUSY |-> busy_cnt_q <= OP_CYCLES)
        else $error("operation ran too long");
    gate_stops_a: assert property (!ENGINE_CLK_EN && !$past(ENGINE_CLK_EN) |-> !OP_BUSY)
        else $error("operation running while gated");
    sleep_halts_a: assert property (SLEEP_REQ [*5] |-> !OP_BUSY)
        else $error("operation running in sleep");
    wake_reload_a: assert property ($fell(SLEEP_REQ) && ENGINE_CLK_EN |-> ##[1:8] CFG_RD_REQ)
        else $error("no fetch after wake");
endmodule : crypto_cfg_loader_asserts

bind crypto_cfg_loader crypto_cfg_loader_asserts #(.OP_CYCLES(OP_CYCLES)) i_chk (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .S_AXI_REQ(S_AXI_REQ), .S_AXI_RSP(S_AXI_RSP),
    .SLEEP_REQ(SLEEP_REQ), .IDLE_REQ(IDLE_REQ), .CFG_RD_REQ(CFG_RD_REQ),
    .CFG_RD_PAGE(CFG_RD_PAGE), .CFG_RD_ACK(CFG_RD_ACK), .CFG_RD_DATA(CFG_RD_DATA),
    .ENGINE_CLK_EN(ENGINE_CLK_EN), .ENGINE_READY(ENGINE_READY), .OP_BUSY(OP_BUSY),
    .IRQ(IRQ));

// file: verification/crypto_engine_reset_config_load_tb.sv
// bench for the loader: AXI4-Lite tasks, start-up load, gating, abort and wake
// assumes the array model answers each fetch 16 cycles after the request
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module crypto_engine_reset_config_load_tb
    import crypto_cfg_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, rst_n = 1'b0, sleep_req = 1'b0, idle_req = 1'b0;
    axil_req_t   rq = '0;
    axil_rsp_t   rs;
    logic        cfg_req, cfg_ack, clk_en, ready, busy, irq;
    logic [1:0]  page, resp;
    logic [31:0] cfg_data, rd_v, word = 32'h0;
    logic [3:0]  ksrc = 4'h0;
    int          failures = 0, n_tests = 0;
    always #12.5 sys_clk = ~sys_clk;
    crypto_cfg_loader #(.OP_CYCLES(16'd40)) i_dut (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .S_AXI_REQ(rq), .S_AXI_RSP(rs),
        .SLEEP_REQ(sleep_req), .IDLE_REQ(idle_req), .CFG_RD_REQ(cfg_req),
        .CFG_RD_PAGE(page), .CFG_RD_ACK(cfg_ack), .CFG_RD_DATA(cfg_data),
        .ENGINE_CLK_EN(clk_en), .ENGINE_READY(ready), .OP_BUSY(busy), .IRQ(irq));
    cfg_array_model i_arr (.clk(sys_clk), .req(cfg_req), .word(word), .dly(4'hF),
        .ack(cfg_ack), .data(cfg_data));
    function automatic logic [31:0] exp_stat(logic [31:0] w, logic [3:0] k);
        return {29'h0, w[1] & ~w[0], k > w[7:4], w[0]};
    endfunction : exp_stat
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        rq.awvalid <= 1'b1; rq.awaddr <= a; rq.wvalid <= 1'b1;
        rq.wdata <= d; rq.wstrb <= 4'hF; rq.bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
        end while (!rs.bvalid);
        rq.bready <= 1'b0;
        resp = rs.bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        rq.arvalid <= 1'b1; rq.araddr <= a; rq.rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rs.arready) rq.arvalid <= 1'b0;
        end while (!rs.rvalid);
        rq.rready <= 1'b0;
        d = rs.rdata;
        resp = rs.rresp;
    endtask : rd
    task automatic wait_lvl(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("wait level", v, s)
    endtask : wait_lvl
    task automatic load_chk;
        wait_lvl(cfg_req, 1'b1);
        rd(OFF_STATUS, rd_v);
        `CHK("status in load", 32'hC0, rd_v)
        wait_lvl(cfg_req, 1'b0);
        rd(OFF_STATUS, rd_v);
        `CHK("status after load", exp_stat(word, ksrc), rd_v)
    endtask : load_chk
    task automatic complete_run;
        $display("failures %0d of %0d checks", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    initial begin
        void'($urandom(32'hFFB65C8F));
        word = $urandom;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wr(OFF_CTRL_LOW, 32'h8001);
        `CHK("go in load", 1'b0, busy)
        load_chk();
        rd(OFF_CTRL_HIGH, rd_v);
        `CHK("high reset", 32'h0, rd_v)
        rd(OFF_IRQ_STAT, rd_v);
        `CHK("load and refuse events", 32'h5, rd_v)
        wr(OFF_IRQ_STAT, 32'h7);
        wr(OFF_CTRL_LOW, 32'h8001);
        `CHK("go taken", 2'b11, {busy, ready})
        wait_lvl(busy, 1'b0);
        repeat (2) @(posedge sys_clk);
        `CHK("done masked", 1'b0, irq)
        wr(OFF_IRQ_MASK, 32'h2);
        repeat (2) @(posedge sys_clk);
        `CHK("done raised", 1'b1, irq)
        wr(OFF_IRQ_STAT, 32'h2);
        repeat (2) @(posedge sys_clk);
        `CHK("done cleared", 1'b0, irq)
        ksrc = 4'($urandom);
        wr(OFF_CTRL_HIGH, {27'h0, 1'b1, ksrc});
        wr(OFF_CTRL_LOW, 32'h8001);
        `CHK("go before off", 1'b1, busy)
        wr(OFF_CTRL_LOW, 32'h0);
        `CHK("abort by off", 2'b00, {busy, ready})
        rd(OFF_CTRL_HIGH, rd_v);
        `CHK("erase cleared", {28'h0, ksrc}, rd_v)
        wr(OFF_CTRL_HIGH, {16'h0, 12'h7FF, ksrc});
        wr(OFF_CTRL_LOW, 32'h8001);
        `CHK("go before gate", 1'b1, busy)
        wr(OFF_PWR, 32'h1);
        repeat (2) @(posedge sys_clk);
        `CHK("gated", 3'b000, {clk_en, busy, ready})
        wr(OFF_CTRL_LOW, 32'h8000);
        rd(OFF_CTRL_HIGH, rd_v);
        `CHK("gated read", 32'h0, rd_v)
        wr(OFF_PWR, 32'h0);
        rd(OFF_CTRL_LOW, rd_v);
        `CHK("low after gate", 32'h0, rd_v)
        rd(OFF_CTRL_HIGH, rd_v);
        `CHK("high after gate", {28'h0, ksrc}, rd_v)
        repeat (8) @(posedge sys_clk);
        wait_lvl(cfg_req, 1'b0);
        // the last pass halts through idle with the halt-in-idle bit set
        for (int i = 0; i < 3; i++) begin
            word = $urandom;
            ksrc = (i == 0) ? 4'hF : 4'($urandom);
            wr(OFF_CTRL_HIGH, {28'h0, ksrc});
            wr(OFF_CTRL_LOW, (i == 2) ? 32'hA001 : 32'h8001);
            `CHK("go before halt", 1'b1, busy)
            if (i == 2) idle_req <= 1'b1;
            else sleep_req <= 1'b1;
            repeat (8) @(posedge sys_clk);
            `CHK("sleep halt", 1'b0, busy)
            sleep_req <= 1'b0;
            idle_req <= 1'b0;
            load_chk();
        end
        wr(8'h40, 32'h1);
        `CHK("bad write", RESP_SLVERR, resp)
        rd(8'h40, rd_v);
        `CHK("bad read", RESP_SLVERR, resp)
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        complete_run();
    end
endmodule : crypto_engine_reset_config_load_tb
